// *** dv/rrc_supply_model.sv ***
// Host and supply model driving the reset inputs
`timescale 1ns/1ps
`default_nettype none
module rrc_supply_model (
  input wire logic clock,
  output logic analog_supply_good,
  output logic digital_io_supply_one_good,
  output logic reset_pin_b,
  output logic regulator_enable_pin
);
  initial
  begin
    analog_supply_good = 1'h1;
    digital_io_supply_one_good = 1'h1;
    reset_pin_b = 1'h1;
    regulator_enable_pin = 1'h0;
  end
  // Callers keep supplies up whenever the enable pin goes low for sleep
  task drive(input logic a, input logic d, input logic p, input logic e);
    @(posedge clock);
    analog_supply_good <= a;
    digital_io_supply_one_good <= d;
    reset_pin_b <= p;
    regulator_enable_pin <= e;
  endtask : drive
endmodule : rrc_supply_model
`default_nettype wire

// *** dv/rrc_top_test.sv ***
// Self-checking bench for reset and retention control
`timescale 1ns/1ps
`default_nettype none
`include "rrc_cfg.svh"
module rrc_top_test;
  logic clock = 1'h0;
  logic rst_b = 1'h0;
  logic ag, dg, pb, pe, wr = 1'h0, rd = 1'h0;
  logic por, hwr, c_aon, c_main, c_seq, slp, reg_on;
  logic [7:0] addr = 8'h00;
  logic [15:0] wdata = 16'h0000;
  logic [15:0] rdata, v;
  int bad_count = 0;
  int num_checks = 0;
  rrc_supply_model pm (.clock(clock), .analog_supply_good(ag),
    .digital_io_supply_one_good(dg), .reset_pin_b(pb),
    .regulator_enable_pin(pe));
  rrc_top uut (.clock(clock), .rst_b(rst_b), .analog_supply_good(ag),
    .digital_io_supply_one_good(dg), .reset_pin_b(pb),
    .regulator_enable_pin(pe), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .por_active(por), .hw_reset_active(hwr),
    .clear_aon(c_aon), .clear_main(c_main), .clear_seq(c_seq),
    .sleep_mode(slp), .core_regulator_on(reg_on));
  initial
  begin
    forever #10 clock = ~clock;
  end
  task final_report;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : final_report
  task chk(input string n, input logic [15:0] e, input logic [15:0] g);
    num_checks++;
    if (g !== e)
    begin
      bad_count++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask : chk
  task cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : cyc
  task wrt(input logic [7:0] a, input logic [15:0] d);
    @(posedge clock);
    wr <= 1'h1;
    addr <= a;
    wdata <= d;
    @(posedge clock);
    wr <= 1'h0;
    #1;
  endtask : wrt
  task rdv(input logic [7:0] a);
    @(posedge clock);
    rd <= 1'h1;
    addr <= a;
    @(posedge clock);
    rd <= 1'h0;
    #1;
    v = rdata;
  endtask : rdv
  task rdc(input logic [7:0] a, input logic [15:0] e);
    rdv(a);
    chk($sformatf("reg %h", a), e, v);
  endtask : rdc
  task fill;
    wrt(`RRC_OFF_SCRATCH_AON, 16'ha5a5);
    wrt(`RRC_OFF_SCRATCH_MAIN, 16'h5a5a);
    wrt(8'h20, 16'h1234);
  endtask : fill
  // Bounded wait for the run state after any release
  task wait_run;
    for (int i = 0; i < 30; i++)
    begin
      rdv(`RRC_OFF_STATUS);
      if (v === {12'h000, rrc_pkg::RRC_RUN})
        return;
    end
    bad_count++;
    $display("[ERR] status exp %h got %h", rrc_pkg::RRC_RUN, v);
    final_report();
  endtask : wait_run
  initial
  begin
    repeat (2) @(posedge clock);
    rst_b <= 1'h1;
    cyc(6);
    chk("por", 16'h0, por);
    chk("reg_on", 16'h1, reg_on);
    rdc(`RRC_OFF_CTRL, `RRC_CTRL_RESET);
    rdc(8'h3c, 16'h0000);
    $display("test start-up done");
    for (int k = 0; k < 2; k++)
    begin
      fill();
      wrt(`RRC_OFF_SWRST, k ? 16'hffff : 16'h0000);
      chk("c_aon", 16'h1, c_aon);
      chk("c_seq", 16'h0, c_seq);
      rdc(`RRC_OFF_SCRATCH_AON, `RRC_AON_RESET);
      rdc(`RRC_OFF_SCRATCH_MAIN, `RRC_MAIN_RESET);
      rdc(8'h20, 16'h1234);
    end
    rdc(`RRC_OFF_SWRST, 16'h0000);
    $display("test software reset done");
    fill();
    pm.drive(1'h1, 1'h1, 1'h0, 1'h1);
    cyc(5);
    chk("hwr", 16'h1, hwr);
    chk("c_main", 16'h1, c_main);
    chk("c_seq", 16'h0, c_seq);
    wrt(`RRC_OFF_SCRATCH_AON, 16'hffff);
    cyc(3);
    chk("c_aon", 16'h1, c_aon);
    pm.drive(1'h1, 1'h1, 1'h1, 1'h1);
    cyc(5);
    chk("hwr", 16'h0, hwr);
    wait_run();
    rdc(`RRC_OFF_SCRATCH_AON, `RRC_AON_RESET);
    rdc(`RRC_OFF_SCRATCH_MAIN, `RRC_MAIN_RESET);
    rdc(8'h20, 16'h1234);
    $display("test pin reset done");
    fill();
    wrt(`RRC_OFF_CTRL, 16'h0000);
    cyc(5);
    chk("reg_on", 16'h1, reg_on);
    pm.drive(1'h1, 1'h1, 1'h1, 1'h0);
    cyc(5);
    chk("reg_on", 16'h0, reg_on);
    chk("slp", 16'h1, slp);
    chk("c_main", 16'h1, c_main);
    chk("c_aon", 16'h0, c_aon);
    rdc(`RRC_OFF_STATUS, {12'h000, rrc_pkg::RRC_SLEEP});
    pm.drive(1'h1, 1'h1, 1'h1, 1'h1);
    wait_run();
    rdc(`RRC_OFF_CTRL, 16'h0000);
    rdc(`RRC_OFF_SCRATCH_AON, 16'ha5a5);
    rdc(`RRC_OFF_SCRATCH_MAIN, `RRC_MAIN_RESET);
    rdc(8'h20, 16'h1234);
    $display("test sleep done");
    pm.drive(1'h0, 1'h1, 1'h0, 1'h1);
    cyc(5);
    chk("por", 16'h1, por);
    chk("hwr", 16'h0, hwr);
    chk("c_seq", 16'h1, c_seq);
    pm.drive(1'h1, 1'h0, 1'h1, 1'h1);
    cyc(5);
    chk("por", 16'h1, por);
    pm.drive(1'h1, 1'h1, 1'h1, 1'h1);
    cyc(6);
    chk("por", 16'h0, por);
    wait_run();
    rdc(8'h20, `RRC_SEQ_RESET);
    rdc(`RRC_OFF_SCRATCH_AON, `RRC_AON_RESET);
    $display("test power-on reset done");
    final_report();
  end
endmodule : rrc_top_test
`default_nettype wire

// *** hw/rrc_sync.sv ***
// Two flip-flop synchroniser for pin levels
`timescale 1ns/1ps
`default_nettype none
module rrc_sync (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic din,
  output logic dout
);
  logic meta_q;
  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      meta_q <= 1'b0;
      dout <= 1'b0;
    end
    else
    begin
      meta_q <= din;
      dout <= meta_q;
    end
  end
endmodule : rrc_sync
`default_nettype wire

// *** hw/rrc_top.sv ***
// Reset and retention control top
`timescale 1ns/1ps
`default_nettype none
`include "rrc_cfg.svh"
module rrc_top (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic analog_supply_good,
  input wire logic digital_io_supply_one_good,
  input wire logic reset_pin_b,
  input wire logic regulator_enable_pin,
  input wire logic [`RRC_ADDR_W-1:0] addr,
  input wire logic [`RRC_DATA_W-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [`RRC_DATA_W-1:0] rdata,
  output logic por_active,
  output logic hw_reset_active,
  output logic clear_aon,
  output logic clear_main,
  output logic clear_seq,
  output logic sleep_mode,
  output logic core_regulator_on
);
  logic analog_ok_s, dio_s, rstpin_s, regpin_s;
  logic por_w, hwr_w, swr_w, sleep_w;
  logic [`RRC_DATA_W-1:0] ctrl_q, aon_q, main_q;
  logic [`RRC_DATA_W-1:0] seq_mem [0:3];
  rrc_pkg::rrc_state_t state_q;

  rrc_sync u_sa (.clock(clock), .rst_b(rst_b), .din(analog_supply_good),
    .dout(analog_ok_s));
  rrc_sync u_sd (.clock(clock), .rst_b(rst_b),
    .din(digital_io_supply_one_good), .dout(dio_s));
  rrc_sync u_sr (.clock(clock), .rst_b(rst_b), .din(reset_pin_b),
    .dout(rstpin_s));
  rrc_sync u_sp (.clock(clock), .rst_b(rst_b), .din(regulator_enable_pin),
    .dout(regpin_s));

  function automatic logic hit(input logic [`RRC_ADDR_W-1:0] a,
    input logic [`RRC_ADDR_W-1:0] off);
    hit = (a == off);
  endfunction : hit

  assign por_w = !analog_ok_s || !dio_s;
  assign hwr_w = !rstpin_s;
  assign swr_w = wr && hit(addr, `RRC_OFF_SWRST);
  assign sleep_w = !ctrl_q[`RRC_CTRL_REGEN_BIT] && !regpin_s;

  // Priority: power-on, then pin, then sleep; a software reset does not mask sleep
  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      clear_aon <= 1'b1;
      clear_main <= 1'b1;
      clear_seq <= 1'b1;
    end
    else
    begin
      clear_seq <= por_w;
      clear_aon <= por_w || hwr_w || swr_w;
      clear_main <= por_w || hwr_w || swr_w || sleep_w;
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      por_active <= 1'b1;
      hw_reset_active <= 1'b0;
      sleep_mode <= 1'b0;
      core_regulator_on <= 1'b1;
    end
    else
    begin
      por_active <= por_w;
      hw_reset_active <= hwr_w && !por_w;
      sleep_mode <= sleep_w && !por_w && !hwr_w;
      core_regulator_on <= !sleep_w;
    end
  end

  // Sequence state: sequencer memory writes are allowed only in the run state
  always_ff @(posedge clock)
  begin
    if (!rst_b)
      state_q <= rrc_pkg::RRC_HOLD;
    else
    begin
      case (state_q)
        rrc_pkg::RRC_RUN:
          if (por_w || hwr_w)
            state_q <= rrc_pkg::RRC_HOLD;
          else if (sleep_w)
            state_q <= rrc_pkg::RRC_SLEEP;
        rrc_pkg::RRC_HOLD:
          if (!por_w && !hwr_w)
            state_q <= rrc_pkg::RRC_RUN;
        rrc_pkg::RRC_SLEEP:
          if (por_w || hwr_w)
            state_q <= rrc_pkg::RRC_HOLD;
          else if (!sleep_w)
            state_q <= rrc_pkg::RRC_WAKE;
        rrc_pkg::RRC_WAKE:
          // A reset arriving in the wake cycle must still hold
          if (por_w || hwr_w)
            state_q <= rrc_pkg::RRC_HOLD;
          else
            state_q <= rrc_pkg::RRC_RUN;
        default:
          state_q <= rrc_pkg::RRC_HOLD;
      endcase
    end
  end

  // Always-on storage, including the regulator enable bit
  always_ff @(posedge clock)
  begin
    if (!rst_b || por_w || hwr_w || swr_w)
    begin
      ctrl_q <= `RRC_CTRL_RESET;
      aon_q <= `RRC_AON_RESET;
    end
    else if (wr && hit(addr, `RRC_OFF_CTRL))
      ctrl_q <= wdata;
    else if (wr && hit(addr, `RRC_OFF_SCRATCH_AON))
      aon_q <= wdata;
  end

  // Other registers: also lost in sleep
  always_ff @(posedge clock)
  begin
    if (!rst_b || por_w || hwr_w || swr_w || sleep_w)
      main_q <= `RRC_MAIN_RESET;
    else if (wr && hit(addr, `RRC_OFF_SCRATCH_MAIN))
      main_q <= wdata;
  end

  // Sequencer memory only cleared by power-on; writes at 0x20..0x2f
  always_ff @(posedge clock)
  begin
    if (!rst_b || por_w)
    begin
      for (int i = 0; i < 4; i++)
        seq_mem[i] <= `RRC_SEQ_RESET;
    end
    else if (wr && addr[7:4] == `RRC_SEQ_PAGE &&
      state_q == rrc_pkg::RRC_RUN)
      seq_mem[addr[3:2]] <= wdata;
  end

  // Read data one cycle after strobe, zero elsewhere
  always_ff @(posedge clock)
  begin
    if (!rst_b)
      rdata <= 16'h0000;
    else if (!rd)
      rdata <= 16'h0000;
    else if (hit(addr, `RRC_OFF_CTRL))
      rdata <= ctrl_q;
    else if (hit(addr, `RRC_OFF_STATUS))
      rdata <= {12'h000, state_q};
    else if (hit(addr, `RRC_OFF_SCRATCH_AON))
      rdata <= aon_q;
    else if (hit(addr, `RRC_OFF_SCRATCH_MAIN))
      rdata <= main_q;
    else if (addr[7:4] == `RRC_SEQ_PAGE)
      rdata <= seq_mem[addr[3:2]];
    else
      rdata <= 16'h0000;
  end

  AST_POR_CLEARS: assert property (@(posedge clock) disable iff (!rst_b)
    por_w |=> clear_seq && clear_aon && clear_main)
    else $error("power-on did not clear all");
  AST_HWR_KEEPS_SEQ: assert property (@(posedge clock) disable iff (!rst_b)
    (hwr_w && !por_w) |=> clear_aon && !clear_seq)
    else $error("hardware reset clearing wrong");
  AST_SWR: assert property (@(posedge clock) disable iff (!rst_b)
    (swr_w && !por_w) |=> clear_aon && clear_main && !clear_seq)
    else $error("software reset clearing wrong");
  AST_SLEEP: assert property (@(posedge clock) disable iff (!rst_b)
    (sleep_w && !por_w && !hwr_w && !swr_w) |=> clear_main && !clear_aon)
    else $error("sleep clearing wrong");
  AST_REGEN: assert property (@(posedge clock) disable iff (!rst_b)
    (ctrl_q[`RRC_CTRL_REGEN_BIT] || regpin_s) |=> core_regulator_on)
    else $error("regulator off while enabled");
  AST_POR_FLAG: assert property (@(posedge clock) disable iff (!rst_b)
    (!analog_ok_s || !dio_s) |=> por_active)
    else $error("power-on flag missing");
  AST_HOLD: assert property (@(posedge clock) disable iff (!rst_b)
    (por_w || hwr_w) |=> state_q != rrc_pkg::RRC_RUN)
    else $error("ran during held reset");
  AST_PIN: assert property (@(posedge clock) disable iff (!rst_b)
    (!rstpin_s && analog_ok_s && dio_s) |=> hw_reset_active)
    else $error("pin reset not seen");
endmodule : rrc_top
`default_nettype wire

// *** include/rrc_cfg.svh ***
// Offsets, field positions and reset values for reset and retention control
`ifndef RRC_CFG_SVH
`define RRC_CFG_SVH
`define RRC_ADDR_W 8
`define RRC_DATA_W 16
`define RRC_OFF_SWRST 8'h00
`define RRC_OFF_CTRL 8'h04
`define RRC_OFF_STATUS 8'h08
`define RRC_OFF_SCRATCH_AON 8'h0c
`define RRC_OFF_SCRATCH_MAIN 8'h10
`define RRC_SEQ_PAGE 4'h2
`define RRC_CTRL_REGEN_BIT 0
`define RRC_CTRL_RESET 16'h0001
`define RRC_AON_RESET 16'h0000
`define RRC_MAIN_RESET 16'h0000
`define RRC_SEQ_RESET 16'h0000
`endif

// *** include/rrc_pkg.sv ***
// Types for reset and retention control
package rrc_pkg;
  typedef enum logic [3:0] {
    RRC_RUN = 4'h1,
    RRC_HOLD = 4'h2,
    RRC_SLEEP = 4'h4,
    RRC_WAKE = 4'h8
  } rrc_state_t;
endpackage : rrc_pkg
